/* core/arsc_defines.svh */
// Register map, field positions, reset values and codes of the converter control block.
// Assumes inclusion by bare name from core/ and verif/ files.
`ifndef ARSC_DEFINES_SVH
`define ARSC_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ARSC_OFF_INSEL   12'h000
`define ARSC_OFF_CTRL    12'h004
`define ARSC_OFF_RES_LO  12'h008
`define ARSC_OFF_RES_HI  12'h00C
`define ARSC_OFF_STATUS  12'h010
`define ARSC_OFF_CLEAR   12'h014
`define ARSC_OFF_IRQ_EN  12'h018

// ****************************************
// Field positions
// ****************************************
`define ARSC_INSEL_REF_HI   7
`define ARSC_INSEL_REF_LO   6
`define ARSC_INSEL_LEFT     5
`define ARSC_INSEL_MUX_HI   4
`define ARSC_INSEL_MUX_LO   0
`define ARSC_CTRL_ENABLE    7
`define ARSC_CTRL_START     6
`define ARSC_EVT_DONE       0

// ****************************************
// Reset values and codes
// ****************************************
`define ARSC_INSEL_RST      8'h00
`define ARSC_CTRL_RST       1'b0
`define ARSC_IRQ_EN_RST     1'b0
`define ARSC_RESULT_RST     10'h000
`define ARSC_SE_FULL        10'h3FF
`define ARSC_DIFF_MIN       10'h200
`define ARSC_DIFF_MAX       10'h1FF
`define ARSC_SE_LIMIT       12'h3FF
`define ARSC_DIFF_HI_LIMIT  12'h1FF
`define ARSC_DIFF_LO_LIMIT  12'hE00
`define ARSC_MUX_DIFF_FIRST 5'h08
`define ARSC_MUX_DIFF_LAST  5'h1D
`define ARSC_SLEEP_IDLE     3'h0
`define ARSC_SLEEP_NOISE    3'h1
`define ARSC_LEFT_SHIFT     6

`endif

/* core/arsc_pkg.sv */
// Types shared by the converter control block.
// Assumes arsc_defines.svh for numeric constants.
package arsc_pkg;

  typedef enum logic [0:0] {
    ARSC_IDLE = 1'b0,
    ARSC_RUN  = 1'b1
  } arsc_state_t;

  typedef enum logic [1:0] {
    ARSC_GAIN_1X   = 2'b00,
    ARSC_GAIN_10X  = 2'b01,
    ARSC_GAIN_200X = 2'b10
  } arsc_gain_t;

  typedef enum logic [1:0] {
    ARSC_REF_EXT    = 2'b00,
    ARSC_REF_SUPPLY = 2'b01,
    ARSC_REF_1V1    = 2'b10,
    ARSC_REF_2V56   = 2'b11
  } arsc_ref_t;

  typedef struct packed {
    arsc_ref_t  reference_select;
    logic [4:0] channel_gain_select;
    logic       differential;
    arsc_gain_t gain;
    logic       extended;
  } arsc_sel_t;

  typedef struct packed {
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
  } arsc_bytes_t;

endpackage : arsc_pkg

/* core/arsc_coder.sv */
// Result coding: saturation of the raw front-end count and byte placement.
// Assumes a 12-bit raw count, unsigned for single-ended, two's complement for differential.
`timescale 1ns/1ps
`default_nettype none
`include "arsc_defines.svh"
module arsc_coder
  import arsc_pkg::*;
(
  input  wire logic [11:0] raw_code,
  input  wire logic        differential,
  input  wire logic [9:0]  stored_result,
  input  wire logic        left_align_select,
  output arsc_bytes_t      bytes,
  output logic [9:0]       coded_result
);

  // ****************************************
  // Saturation
  // ****************************************
  always_comb
  begin
    if (!differential)
    begin
      if (raw_code > `ARSC_SE_LIMIT)
        coded_result = `ARSC_SE_FULL;
      else
        coded_result = raw_code[9:0];
    end
    else if (!raw_code[11] && raw_code > `ARSC_DIFF_HI_LIMIT)
      coded_result = `ARSC_DIFF_MAX;
    else if (raw_code[11] && raw_code < `ARSC_DIFF_LO_LIMIT)
      coded_result = `ARSC_DIFF_MIN;
    else
      coded_result = raw_code[9:0];
  end

  // ****************************************
  // Alignment, follows the select at once
  // ****************************************
  always_comb
  begin
    if (left_align_select)
      bytes = arsc_bytes_t'({stored_result, 6'h00});
    else
      bytes = arsc_bytes_t'({6'h00, stored_result});
  end

endmodule : arsc_coder
`default_nettype wire

/* core/arsc_sleep.sv */
// Noise canceler start: one conversion per halt of the CPU in a quiet sleep mode.
// Assumes sleep_mode and cpu_halted come from the sleep controller on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "arsc_defines.svh"
module arsc_sleep
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] sleep_mode,
  input  wire logic       cpu_halted,
  input  wire logic       converter_enable,
  input  wire logic       busy,
  input  wire logic       done_irq_enable,
  output logic            sleep_go
);

  logic halted_q;
  logic quiet_mode;

  assign quiet_mode = (sleep_mode == `ARSC_SLEEP_IDLE) || (sleep_mode == `ARSC_SLEEP_NOISE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halted_q <= 1'b0;
    else
      halted_q <= cpu_halted;
  end

  // Only the halt edge starts, so a long sleep gives one result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sleep_go <= 1'b0;
    else
      sleep_go <= cpu_halted && !halted_q && quiet_mode && converter_enable
                  && !busy && done_irq_enable;
  end

endmodule : arsc_sleep
`default_nettype wire

/* core/arsc_top.sv */
// Converter control top: APB registers, conversion sequencing, result coding, interrupt.
// Assumes an analog front end that answers ana_req with ana_done and a held 12-bit count,
// both asynchronous to pclk, and a CPU sleep controller on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "arsc_defines.svh"
module arsc_top
  import arsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  sleep_mode,
  input  wire logic        cpu_halted,
  input  wire logic        ana_done,
  input  wire logic [11:0] ana_code,
  output logic             ana_req,
  output arsc_sel_t        ana_sel,
  output logic             irq
);

  // ****************************************
  // Declarations
  // ****************************************
  arsc_state_t state_q;
  logic [7:0]  insel_q;
  logic        enable_q;
  logic        enable_d1_q;
  logic        irq_en_q;
  logic        status_q;
  logic [9:0]  result_q;
  logic        first_q;
  logic        done_s1_q;
  logic        done_s2_q;
  logic        done_s3_q;
  logic [11:0] code_s1_q;
  logic [11:0] code_s2_q;
  logic        wr_en;
  logic        rd_en;
  logic        sw_start;
  logic        sleep_go;
  logic        start;
  logic        finish;
  logic        mapped;
  logic [9:0]  coded;
  arsc_bytes_t bytes;
  logic [7:0]  ctrl_rd;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_diff(input logic [4:0] m);
    is_diff = (m >= `ARSC_MUX_DIFF_FIRST) && (m <= `ARSC_MUX_DIFF_LAST);
  endfunction : is_diff

  function automatic arsc_gain_t gain_of(input logic [4:0] m);
    if (m[4] || !is_diff(m))
      gain_of = ARSC_GAIN_1X;
    else if (m[1])
      gain_of = ARSC_GAIN_200X;
    else
      gain_of = ARSC_GAIN_10X;
  endfunction : gain_of

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // ****************************************
  // APB slave, no wait states
  // ****************************************
  assign wr_en  = psel && penable && pready && pwrite;
  assign rd_en  = psel && !penable && !pwrite;
  assign mapped = hit(paddr, `ARSC_OFF_INSEL) || hit(paddr, `ARSC_OFF_CTRL)
                  || hit(paddr, `ARSC_OFF_RES_LO) || hit(paddr, `ARSC_OFF_RES_HI)
                  || hit(paddr, `ARSC_OFF_STATUS) || hit(paddr, `ARSC_OFF_CLEAR)
                  || hit(paddr, `ARSC_OFF_IRQ_EN);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable && !pready;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && !mapped;
  end

  assign ctrl_rd = {enable_q, (state_q == ARSC_RUN), 6'h00};

  // Read data is captured in setup; alignment applies to the stored result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      if (hit(paddr, `ARSC_OFF_INSEL))
        prdata <= {24'h00_0000, insel_q};
      else if (hit(paddr, `ARSC_OFF_CTRL))
        prdata <= {24'h00_0000, ctrl_rd};
      else if (hit(paddr, `ARSC_OFF_RES_LO))
        prdata <= {24'h00_0000, bytes.result_low_byte};
      else if (hit(paddr, `ARSC_OFF_RES_HI))
        prdata <= {24'h00_0000, bytes.result_high_byte};
      else if (hit(paddr, `ARSC_OFF_STATUS))
        prdata <= {31'h0000_0000, status_q};
      else if (hit(paddr, `ARSC_OFF_IRQ_EN))
        prdata <= {31'h0000_0000, irq_en_q};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      insel_q <= `ARSC_INSEL_RST;
    else if (wr_en && hit(paddr, `ARSC_OFF_INSEL))
      insel_q <= pwdata[7:0];
  end

  // No sleep mode touches the enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_q <= `ARSC_CTRL_RST;
    else if (wr_en && hit(paddr, `ARSC_OFF_CTRL))
      enable_q <= pwdata[`ARSC_CTRL_ENABLE];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_en_q <= `ARSC_IRQ_EN_RST;
    else if (wr_en && hit(paddr, `ARSC_OFF_IRQ_EN))
      irq_en_q <= pwdata[`ARSC_EVT_DONE];
  end

  // Writing zero to the start bit does nothing
  assign sw_start = wr_en && hit(paddr, `ARSC_OFF_CTRL) && pwdata[`ARSC_CTRL_START]
                    && pwdata[`ARSC_CTRL_ENABLE];

  // ****************************************
  // Front end synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      code_s1_q <= 12'h000;
      code_s2_q <= 12'h000;
    end
    else
    begin
      done_s1_q <= ana_done;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      code_s1_q <= ana_code;
      code_s2_q <= code_s1_q;
    end
  end

  // Count is held by the front end long before done, so two flops suffice
  assign finish = (state_q == ARSC_RUN) && enable_q && done_s2_q && !done_s3_q;

  // ****************************************
  // Sequencing
  // ****************************************
  arsc_sleep u_sleep (
    .pclk             (pclk),
    .presetn          (presetn),
    .sleep_mode       (sleep_mode),
    .cpu_halted       (cpu_halted),
    .converter_enable (enable_q),
    .busy             (state_q == ARSC_RUN),
    .done_irq_enable  (irq_en_q),
    .sleep_go         (sleep_go)
  );

  assign start = (state_q == ARSC_IDLE) && (sw_start || (sleep_go && enable_q));

  // A wake by another source does not stop a running conversion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ARSC_IDLE;
    else
      case (state_q)
        ARSC_IDLE: state_q <= start ? ARSC_RUN : ARSC_IDLE;
        ARSC_RUN:
        begin
          if (!enable_q || finish)
            state_q <= ARSC_IDLE;
          else
            state_q <= ARSC_RUN;
        end
        default: state_q <= ARSC_IDLE;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ana_req <= 1'b0;
    else
      ana_req <= (state_q == ARSC_RUN) ? (enable_q && !finish) : start;
  end

  // Re-enabling forces the next conversion to be extended only if it starts three or more clocks after the enabling write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_d1_q <= 1'b0;
      first_q     <= 1'b1;
    end
    else
    begin
      enable_d1_q <= enable_q;
      if (enable_q && !enable_d1_q)
        first_q <= 1'b1;
      else if (finish)
        first_q <= 1'b0;
    end
  end

  // Selection is locked while a conversion runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ana_sel <= '0;
    else if (state_q == ARSC_IDLE && !start)
    begin
      ana_sel.reference_select    <= arsc_ref_t'(insel_q[`ARSC_INSEL_REF_HI:`ARSC_INSEL_REF_LO]);
      ana_sel.channel_gain_select <= insel_q[`ARSC_INSEL_MUX_HI:`ARSC_INSEL_MUX_LO];
      ana_sel.differential        <= is_diff(insel_q[`ARSC_INSEL_MUX_HI:`ARSC_INSEL_MUX_LO]);
      ana_sel.gain                <= gain_of(insel_q[`ARSC_INSEL_MUX_HI:`ARSC_INSEL_MUX_LO]);
      ana_sel.extended            <= first_q;
    end
  end

  // ****************************************
  // Result and interrupt
  // ****************************************
  arsc_coder u_coder (
    .raw_code          (code_s2_q),
    .differential      (ana_sel.differential),
    .stored_result     (result_q),
    .left_align_select (insel_q[`ARSC_INSEL_LEFT]),
    .bytes             (bytes),
    .coded_result      (coded)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_q <= `ARSC_RESULT_RST;
    else if (finish)
      result_q <= coded;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= 1'b0;
    else if (finish)
      status_q <= 1'b1;
    else if (wr_en && hit(paddr, `ARSC_OFF_CLEAR) && pwdata[`ARSC_EVT_DONE])
      status_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= status_q && irq_en_q;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_finish_se_over;
    finish && !ana_sel.differential && (code_s2_q > `ARSC_SE_LIMIT);
  endsequence

  chk_se_saturate: assert property (s_finish_se_over |=> result_q == `ARSC_SE_FULL)
    else $error("single-ended overrange not saturated");
  chk_diff_low_clamp: assert property (finish && ana_sel.differential && code_s2_q[11]
      && (code_s2_q < `ARSC_DIFF_LO_LIMIT) |=> result_q == `ARSC_DIFF_MIN)
    else $error("differential underrange not clamped");
  chk_done_sets_flag: assert property (finish |=> status_q ##1 irq || !irq_en_q)
    else $error("done flag or interrupt missing");
  chk_finish_idles: assert property (finish |=> state_q == ARSC_IDLE && !ana_req)
    else $error("busy not cleared at completion");
  chk_sleep_starts: assert property ($rose(sleep_go) && state_q == ARSC_IDLE && enable_q
      |=> state_q == ARSC_RUN ##1 ana_req)
    else $error("sleep entry did not start conversion");
  chk_busy_holds: assert property (state_q == ARSC_RUN && enable_q && !finish
      |=> state_q == ARSC_RUN)
    else $error("running conversion dropped");
  chk_sel_locked: assert property (state_q == ARSC_RUN && $past(state_q) == ARSC_RUN
      |-> $stable(ana_sel))
    else $error("selection changed during conversion");
  chk_irq_level: assert property (status_q && irq_en_q |=> irq)
    else $error("enabled flag did not raise interrupt");
  chk_sign_read: assert property (rd_en && hit(paddr, `ARSC_OFF_RES_HI) && !insel_q[`ARSC_INSEL_LEFT]
      |=> prdata[1] == $past(result_q[9]))
    else $error("sign bit misplaced in high byte");

endmodule : arsc_top
`default_nettype wire

/* verif/arsc_afe_model.sv */
// Behavioural analog front end facing the converter control block.
// Assumes ana_req from the block on pclk; the bench supplies the count and the latency.
`timescale 1ns/1ps
`default_nettype none
module arsc_afe_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ana_req,
  input  wire logic [11:0] code_in,
  input  wire logic [7:0]  delay,
  output logic             ana_done,
  output logic [11:0]      ana_code
);
  // ****
  // Conversion answer
  // ****
  logic [8:0] cnt_q;

  // Count toggles outside its hold window, so a stale sample never looks valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q    <= 9'h000;
      ana_done <= 1'b0;
      ana_code <= 12'h5A5;
    end
    else if (!ana_req)
    begin
      cnt_q    <= 9'h000;
      ana_done <= 1'b0;
      ana_code <= ~ana_code;
    end
    else
    begin
      if (!ana_done)
        cnt_q <= cnt_q + 9'h001;
      if (cnt_q < {1'b0, delay})
        ana_code <= ~ana_code;
      else if (cnt_q == {1'b0, delay})
        ana_code <= code_in;
      // Count held three clocks before done rises
      if (cnt_q == {1'b0, delay} + 9'h003)
        ana_done <= 1'b1;
    end
  end
endmodule : arsc_afe_model
`default_nettype wire

/* verif/adc_result_and_sleep_start_test.sv */
// Self-checking bench for the converter control top, APB tasks and a front end model.
// Assumes arsc_defines.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "arsc_defines.svh"
module adc_result_and_sleep_start_test
  import arsc_pkg::*;
();
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic [2:0]  sleep_mode = 3'h0;
  logic        cpu_halted = 1'b0;
  logic [11:0] code_in    = 12'h000;
  logic [7:0]  delay      = 8'h02;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ana_req;
  logic        ana_done;
  logic [11:0] ana_code;
  logic        irq;
  arsc_sel_t   ana_sel;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch = 0;
  int          checks     = 0;
  logic [11:0] sc [4]     = '{12'h2A5, 12'h7FF, 12'h000, 12'h3FF};
  logic [9:0]  se [4]     = '{10'h2A5, 10'h3FF, 10'h000, 10'h3FF};
  logic [11:0] dc [4]     = '{12'hE70, 12'hC00, 12'h500, 12'h001};
  logic [9:0]  de [4]     = '{10'h270, 10'h200, 10'h1FF, 10'h001};
  logic [4:0]  mx [5]     = '{5'h03, 5'h0D, 5'h0A, 5'h10, 5'h1E};
  logic [2:0]  dg [5]     = '{3'h0, 3'h5, 3'h6, 3'h4, 3'h0};

  always #5 pclk = ~pclk;

  arsc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .cpu_halted(cpu_halted), .ana_done(ana_done), .ana_code(ana_code),
    .ana_req(ana_req), .ana_sel(ana_sel), .irq(irq));

  arsc_afe_model i_afe (.pclk(pclk), .presetn(presetn), .ana_req(ana_req), .code_in(code_in),
    .delay(delay), .ana_done(ana_done), .ana_code(ana_code));

  // ****
  // Helpers
  // ****
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Ready, data and error taken at the completing rising edge, request held until then
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50)
    begin
      k++;
      @(posedge pclk);
    end
    chk("pready", 1, pready);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc

  task wait_req(input logic v, input int lim);
    int k;
    k = 0;
    @(negedge pclk);
    while (ana_req !== v && k < lim)
    begin
      k++;
      @(negedge pclk);
    end
    chk("ana_req", v, ana_req);
  endtask : wait_req

  task quiet(input int c);
    logic s;
    s = 1'b0;
    repeat (c)
    begin
      @(negedge pclk);
      s = s | ana_req;
    end
    chk("no start", 0, s);
  endtask : quiet

  task go(input logic [11:0] c);
    code_in <= c;
    wr(`ARSC_OFF_CTRL, 32'hC0);
    wait_req(1'b1, 3);
  endtask : go

  task conv(input logic [11:0] c);
    go(c);
    wait_req(1'b0, 200);
  endtask : conv

  task halt(input logic [2:0] m);
    @(posedge pclk);
    sleep_mode <= m;
    cpu_halted <= 1'b1;
  endtask : halt

  task wake;
    @(posedge pclk);
    cpu_halted <= 1'b0;
  endtask : wake

  task settle;
    repeat (2) @(negedge pclk);
  endtask : settle

  // Alignment is applied at read time, so one result serves both layouts
  task chk_res(input logic [7:0] ins, input logic [9:0] e);
    wr(`ARSC_OFF_INSEL, {24'h0, ins & 8'hDF});
    rdc("res lo", `ARSC_OFF_RES_LO, {24'h0, e[7:0]});
    rdc("res hi", `ARSC_OFF_RES_HI, {30'h0, e[9:8]});
    wr(`ARSC_OFF_INSEL, {24'h0, ins | 8'h20});
    rdc("res hi", `ARSC_OFF_RES_HI, {24'h0, e[9:2]});
    rdc("res lo", `ARSC_OFF_RES_LO, {24'h0, e[1:0], 6'h00});
  endtask : chk_res

  initial
  begin
    #300us;
    n_mismatch++;
    $display("watchdog expired");
    end_sim();
  end

  // ****
  // Tests
  // ****
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc("insel", `ARSC_OFF_INSEL, 0);
    rdc("ctrl", `ARSC_OFF_CTRL, 0);
    rdc("status", `ARSC_OFF_STATUS, 0);
    rdc("irq en", `ARSC_OFF_IRQ_EN, 0);
    rdc("res lo", `ARSC_OFF_RES_LO, 0);
    rdc("unmapped", 12'h1FC, 0);
    chk("pslverr", 1, err);
    $display("done: reset");
    wr(`ARSC_OFF_CTRL, 32'h80);
    quiet(6);
    for (int i = 0; i < 4; i++)
    begin
      conv(sc[i]);
      rdc("status", `ARSC_OFF_STATUS, 1);
      chk_res(8'h43, se[i]);
    end
    delay <= 8'd40;
    go(12'h155);
    rdc("busy", `ARSC_OFF_CTRL, 32'hC0);
    wr(`ARSC_OFF_CTRL, 32'h80);
    rdc("busy", `ARSC_OFF_CTRL, 32'hC0);
    wait_req(1'b0, 200);
    rdc("idle", `ARSC_OFF_CTRL, 32'h80);
    delay <= 8'd2;
    $display("done: single-ended");
    for (int r = 0; r < 4; r++)
    begin
      wr(`ARSC_OFF_INSEL, {24'h0, r[1:0], 6'h03});
      conv(12'h3C3);
      go({10'h040, r[1:0]});
      chk("reference", r, ana_sel.reference_select);
      wait_req(1'b0, 200);
      rdc("res lo", `ARSC_OFF_RES_LO, r);
    end
    for (int i = 0; i < 5; i++)
    begin
      wr(`ARSC_OFF_INSEL, {24'h0, 3'b110, mx[i]});
      go(12'h000);
      chk("channel", mx[i], ana_sel.channel_gain_select);
      chk("diff gain", dg[i], {ana_sel.differential, ana_sel.gain});
      wait_req(1'b0, 200);
    end
    wr(`ARSC_OFF_INSEL, 32'hCD);
    for (int i = 0; i < 4; i++)
    begin
      conv(dc[i]);
      chk_res(8'hCD, de[i]);
    end
    $display("done: coding");
    wr(`ARSC_OFF_CLEAR, 1);
    wr(`ARSC_OFF_IRQ_EN, 1);
    conv(12'h0AA);
    settle();
    chk("irq", 1, irq);
    wr(`ARSC_OFF_IRQ_EN, 0);
    settle();
    chk("irq masked", 0, irq);
    wr(`ARSC_OFF_IRQ_EN, 1);
    settle();
    chk("irq", 1, irq);
    wr(`ARSC_OFF_CLEAR, 1);
    settle();
    chk("irq cleared", 0, irq);
    rdc("status", `ARSC_OFF_STATUS, 0);
    rdc("clear", `ARSC_OFF_CLEAR, 0);
    $display("done: interrupt");
    for (int m = 0; m < 2; m++)
    begin
      halt(m[2:0]);
      wait_req(1'b1, 5);
      wait_req(1'b0, 200);
      settle();
      chk("wake irq", 1, irq);
      wake();
      wr(`ARSC_OFF_CLEAR, 1);
    end
    for (int m = 2; m < 8; m++)
    begin
      halt(m[2:0]);
      quiet(8);
      wake();
      rdc("enable kept", `ARSC_OFF_CTRL, 32'h80);
    end
    wr(`ARSC_OFF_CTRL, 0);
    halt(3'h1);
    quiet(8);
    wake();
    wr(`ARSC_OFF_CTRL, 32'h80);
    wr(`ARSC_OFF_IRQ_EN, 0);
    halt(3'h1);
    quiet(8);
    wake();
    wr(`ARSC_OFF_IRQ_EN, 1);
    delay <= 8'd40;
    halt(3'h1);
    wait_req(1'b1, 5);
    wake();
    wait_req(1'b0, 200);
    settle();
    chk("early wake irq", 1, irq);
    wr(`ARSC_OFF_CLEAR, 1);
    go(12'h0F0);
    halt(3'h1);
    wait_req(1'b0, 200);
    quiet(10);
    chk("busy sleep irq", 1, irq);
    wake();
    wr(`ARSC_OFF_CLEAR, 1);
    $display("done: sleep");
    wr(`ARSC_OFF_CTRL, 0);
    wr(`ARSC_OFF_CTRL, 32'h80);
    go(12'h000);
    chk("extended", 1, ana_sel.extended);
    wait_req(1'b0, 200);
    go(12'h000);
    chk("extended", 0, ana_sel.extended);
    wait_req(1'b0, 200);
    $display("done: re-enable");
    end_sim();
  end
endmodule : adc_result_and_sleep_start_test
`default_nettype wire
